// ---- rtl/t1dl_pkg.sv ----
/*
  Constants shared by the byte-wide link port, its host-side controller and
  the ones-run counter. Assumes one common clock for both ends.
*/
package t1dl_pkg;
  // Device register offsets on its own byte port
  localparam logic [7:0] REG_RX_LINK_BYTE = 8'h28;
  localparam logic [7:0] REG_RX_MATCH_A = 8'h29;
  localparam logic [7:0] REG_RX_MATCH_B = 8'h2a;
  localparam logic [7:0] REG_TX_LINK_BYTE = 8'h7e;
  localparam logic [7:0] REG_STATUS = 8'h40;
  localparam logic [7:0] REG_IRQ_MASK = 8'h41;
  localparam logic [7:0] REG_CONTROL = 8'h42;
  // Status and mask bit positions
  localparam int BIT_MATCH = 2;
  localparam int BIT_TX_EMPTY = 3;
  localparam int BIT_RX_FULL = 4;
  // Control bit positions
  localparam int BIT_RX_DESTUFF = 0;
  localparam int BIT_FS_SOURCE = 2;
  localparam int BIT_TX_STUFF = 4;
  localparam int BIT_MF_LOAD = 5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] FLAG_BITS = 8'h1c;
  // Ones-run counting
  localparam logic [2:0] RUN_STUFF = 3'd5;
  localparam logic [2:0] RUN_SAT = 3'd6;
  localparam logic [2:0] LAST_BIT = 3'd7;
  // Host controller registers (byte addresses)
  localparam logic [11:0] HREG_CMD = 12'h000;
  localparam logic [11:0] HREG_RESULT = 12'h004;
  localparam logic [11:0] HREG_IRQ_STATUS = 12'h008;
  localparam logic [11:0] HREG_IRQ_MASK = 12'h00c;
  localparam int CMD_WDATA_LSB = 8;
  localparam int CMD_WRITE = 16;
  localparam int CMD_GO = 17;
  localparam int RES_BUSY = 8;
  localparam int HIRQ_DEVICE = 0;
  localparam int HIRQ_DONE = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage : t1dl_pkg

// ---- rtl/t1dl_port_if.sv ----
/*
  Byte register port between host controller and link port device.
  Assumes both ends run on the clock given here.
*/
`timescale 1ns/100ps
`default_nettype none
interface t1dl_port_if (
  input wire logic clock
);
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic int_n;
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output int_n);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input int_n);
endinterface : t1dl_port_if
`default_nettype wire

// ---- rtl/t1dl_ones_run.sv ----
/*
  Saturating counter of consecutive ones in a bit stream.
  Assumes step marks a bit in the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module t1dl_ones_run
  import t1dl_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic step,
  input wire logic bit_in,
  output logic [2:0] run
);
  // Saturation keeps six-or-more distinct from exactly five
  wire logic [2:0] run_nxt = !bit_in ? 3'd0 : (run == RUN_SAT) ? run : 3'(run + 3'd1);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run <= 3'd0;
    end else if (ce && step) begin
      run <= run_nxt;
    end
  end
endmodule : t1dl_ones_run
`default_nettype wire

// ---- rtl/t1dl_link_port.sv ----
/*
  Byte-wide link/Fs port of a T1 framer: receive shifter with destuffer and
  match compare, transmit serialiser with stuffer, status, mask, interrupt.
  Assumes the framer pulses rx_slot/tx_slot once per link or Fs bit position
  and mf_boundary once per multiframe, all on this clock.
*/
// The AHB-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module t1dl_link_port
  import t1dl_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  t1dl_port_if.dev port,
  input wire logic rx_slot,
  input wire logic rx_bit,
  input wire logic tx_slot,
  input wire logic mf_boundary,
  input wire logic d4_mode,
  input wire logic hdlc_tx_active,
  output logic tx_bit,
  output logic tx_bit_valid
);
  logic [7:0] rx_link_byte_r;
  logic [7:0] rx_match_byte_a_r;
  logic [7:0] rx_match_byte_b_r;
  logic [7:0] tx_link_byte_r;
  logic [7:0] status_r;
  logic [7:0] mask_r;
  logic [7:0] control_r;
  logic [7:0] rx_shift_r;
  logic [2:0] rx_count_r;
  logic [7:0] tx_cur_r;
  logic [2:0] tx_index_r;
  logic [7:0] rdata_r;
  logic int_n_r;
  logic [2:0] rx_run;
  logic [2:0] tx_run;

  // Same address compare serves write decode and read select
  function automatic logic reg_hit(
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    return addr == offset;
  endfunction : reg_hit

  // Bit counters wrap after the eighth bit of a byte
  function automatic logic [2:0] wrap_inc(
    input logic [2:0] count
  );
    return 3'(count + 3'd1);
  endfunction : wrap_inc

  // Hardware set wins over a same-cycle write-one clear
  function automatic logic [7:0] sticky_nxt(
    input logic [7:0] flags,
    input logic [7:0] clr_bits,
    input logic [7:0] set_bits
  );
    return (flags & ~clr_bits) | set_bits;
  endfunction : sticky_nxt

  // Either programmed byte counts as a match
  function automatic logic byte_hit(
    input logic [7:0] value,
    input logic [7:0] match_a,
    input logic [7:0] match_b
  );
    return (value == match_a) || (value == match_b);
  endfunction : byte_hit

  // Register select, shared by write strobes and read data
  wire logic sel_rx_byte = reg_hit(port.addr, REG_RX_LINK_BYTE);
  wire logic sel_match_a = reg_hit(port.addr, REG_RX_MATCH_A);
  wire logic sel_match_b = reg_hit(port.addr, REG_RX_MATCH_B);
  wire logic sel_tx_byte = reg_hit(port.addr, REG_TX_LINK_BYTE);
  wire logic sel_status = reg_hit(port.addr, REG_STATUS);
  wire logic sel_mask = reg_hit(port.addr, REG_IRQ_MASK);
  wire logic sel_control = reg_hit(port.addr, REG_CONTROL);

  // Register decode
  wire logic wr_rx_match_a = port.wr && sel_match_a;
  wire logic wr_rx_match_b = port.wr && sel_match_b;
  wire logic wr_tx_byte = port.wr && sel_tx_byte;
  wire logic wr_status = port.wr && sel_status;
  wire logic wr_mask = port.wr && sel_mask;
  wire logic wr_control = port.wr && sel_control;

  wire logic rx_destuff_enable = control_r[BIT_RX_DESTUFF];
  wire logic fs_source_select = control_r[BIT_FS_SOURCE];
  wire logic tx_stuff_enable = control_r[BIT_TX_STUFF];
  wire logic multiframe_load_enable = control_r[BIT_MF_LOAD];

  // Receive path
  wire logic rx_drop = rx_destuff_enable && !rx_bit && (rx_run == RUN_STUFF);
  wire logic rx_take = rx_slot && !rx_drop;
  wire logic [7:0] rx_assembled = {rx_bit, rx_shift_r[7:1]};
  wire logic rx_done = rx_take && (rx_count_r == LAST_BIT);
  wire logic rx_hit = byte_hit(rx_assembled, rx_match_byte_a_r, rx_match_byte_b_r);
  wire logic rx_match = rx_done && rx_hit;

  t1dl_ones_run rx_ones (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .step(rx_slot),
    .bit_in(rx_bit),
    .run(rx_run)
  );

  // Transmit path; HDLC or framer-sourced Fs takes the slot away from us
  wire logic tx_owned = !hdlc_tx_active && !(d4_mode && fs_source_select);
  wire logic tx_step = tx_slot && tx_owned;
  // Stuffing runs across byte boundaries; a stuffed zero holds the index
  wire logic tx_stuff = tx_stuff_enable && (tx_run == RUN_STUFF);
  wire logic tx_out = tx_stuff ? 1'b0 : tx_cur_r[tx_index_r];
  wire logic tx_data_step = tx_step && !tx_stuff;
  wire logic tx_last = tx_data_step && (tx_index_r == LAST_BIT);
  wire logic tx_mf_load = multiframe_load_enable && mf_boundary;

  t1dl_ones_run tx_ones (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .step(tx_step),
    .bit_in(tx_out),
    .run(tx_run)
  );

  // Status: hardware set wins over a same-cycle write-one clear
  wire logic [7:0] status_set = {3'b000, rx_done, tx_last, rx_match, 2'b00};
  wire logic [7:0] status_clr = wr_status ? port.wdata : 8'h00;
  wire logic [7:0] status_nxt = sticky_nxt(status_r, status_clr, status_set);

  wire logic [7:0] read_mux =
    sel_rx_byte ? rx_link_byte_r :
    sel_match_a ? rx_match_byte_a_r :
    sel_match_b ? rx_match_byte_b_r :
    sel_tx_byte ? tx_link_byte_r :
    sel_status ? status_r :
    sel_mask ? mask_r :
    sel_control ? control_r : 8'h00;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_match_byte_a_r <= RESET_BYTE;
      rx_match_byte_b_r <= RESET_BYTE;
      tx_link_byte_r <= RESET_BYTE;
      mask_r <= RESET_BYTE;
      control_r <= RESET_BYTE;
      status_r <= RESET_BYTE;
      rdata_r <= RESET_BYTE;
    end else if (ce) begin
      if (wr_rx_match_a) rx_match_byte_a_r <= port.wdata;
      if (wr_rx_match_b) rx_match_byte_b_r <= port.wdata;
      if (wr_tx_byte) tx_link_byte_r <= port.wdata;
      if (wr_mask) mask_r <= port.wdata & FLAG_BITS;
      if (wr_control) control_r <= port.wdata;
      status_r <= status_nxt;
      if (port.rd) rdata_r <= read_mux;
    end
  end

  // Receive shifter; an unread byte is simply replaced by the next
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_shift_r <= RESET_BYTE;
      rx_count_r <= 3'd0;
      rx_link_byte_r <= RESET_BYTE;
    end else if (ce && rx_take) begin
      rx_shift_r <= rx_assembled;
      rx_count_r <= wrap_inc(rx_count_r);
      if (rx_done) rx_link_byte_r <= rx_assembled;
    end
  end

  // Serialiser; an unchanged holding byte is sent again
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_cur_r <= RESET_BYTE;
      tx_index_r <= 3'd0;
    end else if (ce) begin
      if (tx_mf_load) begin
        tx_cur_r <= tx_link_byte_r;
        tx_index_r <= 3'd0;
      end else if (tx_data_step) begin
        tx_index_r <= wrap_inc(tx_index_r);
        if (tx_last && !multiframe_load_enable) tx_cur_r <= tx_link_byte_r;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_bit <= 1'b0;
      tx_bit_valid <= 1'b0;
      int_n_r <= 1'b1;
    end else if (ce) begin
      if (tx_step) tx_bit <= tx_out;
      tx_bit_valid <= tx_owned;
      int_n_r <= ~|(status_r & mask_r);
    end
  end

  assign port.rdata = rdata_r;
  assign port.int_n = int_n_r;
endmodule : t1dl_link_port
`default_nettype wire

// ---- rtl/t1dl_host_ctrl.sv ----
/*
  Host-side controller: AHB-Lite slave whose command register drives single
  reads and writes on the link port's byte register port, and which turns the
  port's interrupt into a sticky, maskable level interrupt.
  Assumes the AHB clock is the port clock; zero-wait single word transfers.
*/
`timescale 1ns/100ps
`default_nettype none
module t1dl_host_ctrl
  import t1dl_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  t1dl_port_if.host port,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq
);
  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} t1dl_hstate_type;
  t1dl_hstate_type state_r;

  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic write_r;
  logic [7:0] result_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;
  logic dwr_r;
  logic drd_r;
  logic ph_write_r;
  logic [11:0] ph_addr_r;

  // Only full-word accesses are expected; hsize is not checked
  wire logic addr_phase = hsel && (htrans == HTRANS_NONSEQ) && hready;
  wire logic data_wr = ph_write_r;
  wire logic wr_cmd = data_wr && (ph_addr_r == HREG_CMD);
  wire logic wr_irq_status = data_wr && (ph_addr_r == HREG_IRQ_STATUS);
  wire logic wr_irq_mask = data_wr && (ph_addr_r == HREG_IRQ_MASK);
  // A go while busy is dropped rather than queued
  wire logic start = wr_cmd && hwdata[CMD_GO] && (state_r == H_IDLE);
  wire logic busy = (state_r != H_IDLE);
  wire logic cmd_done = (state_r == H_WAIT);
  // Device interrupt caught as a level every cycle it is low
  wire logic [1:0] irq_set = {cmd_done, !port.int_n};
  wire logic [1:0] irq_clr = wr_irq_status ? hwdata[1:0] : 2'b00;
  wire logic [1:0] irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;
  wire logic [11:0] rd_addr = haddr[11:0];
  wire logic hi_zero = (haddr[31:12] == 20'h00000);
  // Read data sampled in the address phase, so a write just before is not seen
  wire logic [31:0] read_mux =
    !hi_zero ? 32'h00000000 :
    (rd_addr == HREG_CMD) ? {14'h0, 1'b0, write_r, wdata_r, addr_r} :
    (rd_addr == HREG_RESULT) ? {23'h0, busy, result_r} :
    (rd_addr == HREG_IRQ_STATUS) ? {30'h0, irq_status_r} :
    (rd_addr == HREG_IRQ_MASK) ? {30'h0, irq_mask_r} : 32'h00000000;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ph_write_r <= 1'b0;
      ph_addr_r <= 12'h000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      ph_write_r <= addr_phase && hwrite && hi_zero;
      if (addr_phase) ph_addr_r <= rd_addr;
      if (addr_phase && !hwrite) hrdata <= read_mux;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      write_r <= 1'b0;
      irq_status_r <= 2'b00;
      irq_mask_r <= 2'b00;
      irq <= 1'b0;
    end else if (ce) begin
      if (wr_cmd && !busy) begin
        addr_r <= hwdata[7:0];
        wdata_r <= hwdata[CMD_WDATA_LSB +: 8];
        write_r <= hwdata[CMD_WRITE];
      end
      if (wr_irq_mask) irq_mask_r <= hwdata[1:0];
      irq_status_r <= irq_status_nxt;
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  // One-cycle strobe, then one cycle for the device's registered answer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= H_IDLE;
      dwr_r <= 1'b0;
      drd_r <= 1'b0;
      result_r <= 8'h00;
    end else if (ce) begin
      unique case (state_r)
        H_IDLE: begin
          if (start) begin
            state_r <= H_ISSUE;
            dwr_r <= hwdata[CMD_WRITE];
            drd_r <= !hwdata[CMD_WRITE];
          end
        end
        H_ISSUE: begin
          state_r <= H_WAIT;
          dwr_r <= 1'b0;
          drd_r <= 1'b0;
        end
        H_WAIT: begin
          state_r <= H_IDLE;
          if (!write_r) result_r <= port.rdata;
        end
      endcase
    end
  end

  assign port.addr = addr_r;
  assign port.wdata = wdata_r;
  assign port.wr = dwr_r;
  assign port.rd = drd_r;
endmodule : t1dl_host_ctrl
`default_nettype wire

// ---- testbench/t1dl_port_chk.sv ----
/*
  Checker on the byte register port between host controller and link port.
  Assumes one clock and the port reset of the testbench.
*/
`timescale 1ns/100ps
`default_nettype none
module t1dl_port_chk
  import t1dl_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic int_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  wire logic mapped = addr == REG_RX_LINK_BYTE || addr == REG_RX_MATCH_A
    || addr == REG_RX_MATCH_B || addr == REG_TX_LINK_BYTE || addr == REG_STATUS
    || addr == REG_IRQ_MASK || addr == REG_CONTROL;
  sequence s_mask_off;
    wr && addr == REG_IRQ_MASK && wdata == 8'h00;
  endsequence
  sequence s_int_quiet;
    ##2 int_n [*3];
  endsequence
  property p_wr_pulse;
    wr |=> !wr;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("wr longer than one cycle");
  property p_rd_pulse;
    rd |=> !rd;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("rd longer than one cycle");
  property p_one_op;
    !(wr && rd);
  endproperty
  a_one_op: assert property (p_one_op) else $error("wr and rd together");
  property p_rdata_hold;
    !rd |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved without rd");
  property p_unmapped;
    rd && !mapped |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_bits;
    rd && addr == REG_STATUS |=> (rdata & ~FLAG_BITS) == 8'h00;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status spare bits set");
  property p_mask_bits;
    rd && addr == REG_IRQ_MASK |=> (rdata & ~FLAG_BITS) == 8'h00;
  endproperty
  a_mask_bits: assert property (p_mask_bits) else $error("mask spare bits set");
  property p_mask_off;
    s_mask_off |-> s_int_quiet;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("int_n low with all masked");
endmodule : t1dl_port_chk
`default_nettype wire

// ---- testbench/t1_data_link_byte_port_tb.sv ----
/*
  Testbench: host controller and link port joined by the port interface.
  Assumes AHB-Lite single word transfers; drives the line side directly.
*/
`timescale 1ns/100ps
`default_nettype none
module t1_data_link_byte_port_tb
  import t1dl_pkg::*;
();
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic rx_slot = 1'b0;
  logic rx_bit = 1'b0;
  logic tx_slot = 1'b0;
  logic mf_boundary = 1'b0;
  logic d4_mode = 1'b0;
  logic hdlc_tx_active = 1'b0;
  wire logic hreadyout, hresp, irq, tx_bit, tx_bit_valid;
  wire logic [31:0] hrdata;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int i;
  logic [31:0] r;
  logic [7:0] q;
  logic b;
  logic [16:0] v;
  t1dl_port_if i_port (.clock(clock));
  t1dl_host_ctrl i_t1dl_host_ctrl (.clock(clock), .rst_b(rst_b), .ce(ce), .port(i_port),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq));
  t1dl_link_port i_t1dl_link_port (.clock(clock), .rst_b(rst_b), .ce(ce), .port(i_port),
    .rx_slot(rx_slot), .rx_bit(rx_bit), .tx_slot(tx_slot), .mf_boundary(mf_boundary),
    .d4_mode(d4_mode), .hdlc_tx_active(hdlc_tx_active), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid));
  t1dl_port_chk i_t1dl_port_chk (.clock(clock), .rst_b(rst_b), .addr(i_port.addr),
    .wdata(i_port.wdata), .wr(i_port.wr), .rd(i_port.rd), .rdata(i_port.rdata),
    .int_n(i_port.int_n));
  initial forever #2.5 clock = ~clock;
  task results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  // Hang guard, generous against the several hundred cycles needed
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      results();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] o);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    o = hrdata;
  endtask : ahb
  // Polls until busy drops; a stuck command ends at the hang guard
  task dev(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] o);
    logic [31:0] t;
    ahb(1'b1, HREG_CMD, {14'h0, 1'b1, w, d, a}, t);
    do ahb(1'b0, HREG_RESULT, 32'h0, t); while (t[RES_BUSY] !== 1'b0);
    o = t[7:0];
  endtask : dev
  task rx(input logic bit_v);
    @(posedge clock);
    rx_slot <= 1'b1;
    rx_bit <= bit_v;
    @(posedge clock);
    rx_slot <= 1'b0;
  endtask : rx
  task tx(output logic o);
    @(posedge clock);
    tx_slot <= 1'b1;
    @(posedge clock);
    tx_slot <= 1'b0;
    #1 o = tx_bit;
  endtask : tx
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    dev(1'b0, REG_CONTROL, 8'h00, q);
    chk("control", 8'h00, q);
    dev(1'b0, REG_STATUS, 8'h00, q);
    chk("status", 8'h00, q);
    chk("hresp", 1'b0, hresp);
    dev(1'b1, REG_RX_MATCH_A, 8'ha5, q);
    dev(1'b1, REG_RX_MATCH_B, 8'h3c, q);
    dev(1'b1, 8'h50, 8'h77, q);
    dev(1'b1, REG_RX_LINK_BYTE, 8'h99, q);
    dev(1'b0, REG_RX_MATCH_A, 8'h00, q);
    chk("match_a", 8'ha5, q);
    dev(1'b0, 8'h50, 8'h00, q);
    chk("unmapped", 8'h00, q);
    dev(1'b0, REG_RX_LINK_BYTE, 8'h00, q);
    chk("rx_byte ro", 8'h00, q);
    $display("test registers done");
    dev(1'b1, REG_IRQ_MASK, 8'h14, q);
    ahb(1'b1, HREG_IRQ_MASK, 32'h1, r);
    v = 17'h0003c;
    for (i = 0; i < 8; i++) rx(v[i]);
    dev(1'b0, REG_RX_LINK_BYTE, 8'h00, q);
    chk("rx_byte", 8'h3c, q);
    dev(1'b0, REG_STATUS, 8'h00, q);
    chk("status", 8'h14, q);
    chk("int_n", 1'b0, i_port.int_n);
    chk("irq", 1'b1, irq);
    dev(1'b1, REG_STATUS, 8'hff, q);
    ahb(1'b1, HREG_IRQ_STATUS, 32'h3, r);
    repeat (2) @(posedge clock);
    chk("int_n", 1'b1, i_port.int_n);
    chk("irq", 1'b0, irq);
    $display("test receive done");
    dev(1'b1, REG_CONTROL, 8'h01, q);
    v = 17'h07f9f;
    for (i = 0; i < 9; i++) rx(v[i]);
    dev(1'b0, REG_RX_LINK_BYTE, 8'h00, q);
    chk("destuff", 8'hdf, q);
    for (i = 9; i < 17; i++) rx(v[i]);
    dev(1'b0, REG_RX_LINK_BYTE, 8'h00, q);
    chk("six ones", 8'h3f, q);
    $display("test destuff done");
    dev(1'b1, REG_TX_LINK_BYTE, 8'h1f, q);
    dev(1'b1, REG_CONTROL, 8'h10, q);
    for (i = 0; i < 16; i++) begin
      tx(b);
      dev(1'b0, REG_STATUS, 8'h00, q);
      if (q[BIT_TX_EMPTY] === 1'b1) break;
    end
    dev(1'b1, REG_STATUS, 8'hff, q);
    v = 17'h03e1f;
    for (i = 0; i < 17; i++) begin
      tx(b);
      chk("tx_bit", v[i], b);
    end
    tx(b);
    chk("tx_bit", 1'b0, b);
    dev(1'b0, REG_STATUS, 8'h00, q);
    chk("tx_empty", 8'h08, q);
    chk("tx_valid", 1'b1, tx_bit_valid);
    hdlc_tx_active <= 1'b1;
    repeat (3) @(posedge clock);
    chk("tx_valid", 1'b0, tx_bit_valid);
    hdlc_tx_active <= 1'b0;
    dev(1'b1, REG_IRQ_MASK, 8'h00, q);
    $display("test transmit done");
    ahb(1'b0, HREG_IRQ_STATUS, 32'h0, r);
    chk("irq_status", 32'h3, r);
    d4_mode <= 1'b1;
    dev(1'b1, REG_TX_LINK_BYTE, 8'h1c, q);
    dev(1'b1, REG_CONTROL, 8'h20, q);
    @(posedge clock);
    mf_boundary <= 1'b1;
    @(posedge clock);
    mf_boundary <= 1'b0;
    v = 17'h01c1c;
    for (i = 0; i < 16; i++) begin
      tx(b);
      chk("fs_bit", v[i], b);
    end
    dev(1'b1, REG_CONTROL, 8'h24, q);
    repeat (3) @(posedge clock);
    chk("fs_release", 1'b0, tx_bit_valid);
    $display("test fs insertion done");
    results();
  end
endmodule : t1_data_link_byte_port_tb
`default_nettype wire
